// [verilog/adcrt_top.sv]
// read-triggered converter engine with its AHB-Lite register slave
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module adcrt_top
  import adcrt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_ref_clk,
  input wire logic [15:0] analog_code,
  output logic conversion_busy,
  output logic irq
);

  // ----------------------------------------
  // reference clock and divider
  // ----------------------------------------
  logic ref_lvl, ref_prev_q, ref_rise, conv_tick;

  adcrt_sync u_ref_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(ext_ref_clk),
    .level(ref_lvl)
  );

  assign ref_rise = ref_lvl & ~ref_prev_q;

  logic div_sel_q, div_sel_d;

  adcrt_clkdiv u_div (
    .clock(clock),
    .rstn(rstn),
    .ref_rise(ref_rise),
    .div_sel(div_sel_q),
    .conv_tick(conv_tick)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic addr_ok, rd_req, trigger;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;

  // sub-word sizes are not expected; the full word is decoded regardless
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_req = addr_ok & ~hwrite;
  assign trigger = rd_req & (haddr[7:0] == ADCRT_RESULT_OFS);

  // ----------------------------------------
  // conversion engine
  // ----------------------------------------
  adcrt_state_t state_q, state_d;
  logic [4:0] tcnt_q, tcnt_d;
  logic [15:0] sample_q, sample_d;
  logic done_q, done_d;
  logic conv_end;
  adcrt_result_t result;

  always_comb begin
    state_d = state_q;
    tcnt_d = tcnt_q;
    sample_d = sample_q;
    done_d = done_q;
    conv_end = 1'b0;
    case (state_q)
      ADCRT_IDLE: begin
        if (trigger) begin
          state_d = ADCRT_CONV;
          tcnt_d = 5'h00;
          done_d = 1'b0;
        end
      end
      ADCRT_CONV: begin
        // triggers are ignored here so the running result is kept intact
        if (conv_tick) begin
          if (tcnt_q == ADCRT_CONV_TICKS - 5'h01) begin
            state_d = ADCRT_IDLE;
            sample_d = analog_code;
            done_d = 1'b1;
            conv_end = 1'b1;
          end else begin
            tcnt_d = tcnt_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = ADCRT_IDLE;
      end
    endcase
  end

  // read returns status and sample as they stand before the trigger acts
  always_comb begin
    result.done = done_q;
    result.rsvd = 15'h0000;
    result.sample = sample_q;
  end

  // ----------------------------------------
  // registers and interrupt
  // ----------------------------------------
  logic int_sts_q, int_sts_d, int_mask_q, int_mask_d;
  logic wr_status, wr_mask, wr_div;

  assign wr_status = wr_pend_q & (wr_addr_q == ADCRT_INT_STATUS_OFS);
  assign wr_mask = wr_pend_q & (wr_addr_q == ADCRT_INT_MASK_OFS);
  assign wr_div = wr_pend_q & (wr_addr_q == ADCRT_CLKDIV_OFS);

  always_comb begin
    wr_pend_d = addr_ok & hwrite;
    wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
    div_sel_d = wr_div ? hwdata[ADCRT_DIV_SEL_BIT] : div_sel_q;
    int_mask_d = wr_mask ? hwdata[ADCRT_INT_DONE_BIT] : int_mask_q;
    // a completion in the clearing cycle wins over the clear
    int_sts_d = (int_sts_q & ~(wr_status & hwdata[ADCRT_INT_DONE_BIT])) | conv_end;
    hrdata_d = hrdata_q;
    if (rd_req) begin
      case (haddr[7:0])
        ADCRT_RESULT_OFS: hrdata_d = result;
        ADCRT_CLKDIV_OFS: hrdata_d = 32'(div_sel_q) << ADCRT_DIV_SEL_BIT;
        ADCRT_INT_STATUS_OFS: hrdata_d = {31'h0, int_sts_q};
        ADCRT_INT_MASK_OFS: hrdata_d = {31'h0, int_mask_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_prev_q <= 1'b0;
      state_q <= ADCRT_IDLE;
      tcnt_q <= 5'h00;
      sample_q <= ADCRT_SAMPLE_RST;
      done_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      div_sel_q <= ADCRT_DIV_SEL_RST;
      int_sts_q <= ADCRT_INT_STATUS_RST;
      int_mask_q <= ADCRT_INT_MASK_RST;
    end else begin
      ref_prev_q <= ref_lvl;
      state_q <= state_d;
      tcnt_q <= tcnt_d;
      sample_q <= sample_d;
      done_q <= done_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      div_sel_q <= div_sel_d;
      int_sts_q <= int_sts_d;
      int_mask_q <= int_mask_d;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign conversion_busy = (state_q == ADCRT_CONV);
  assign irq = int_sts_q & int_mask_q;

endmodule // adcrt_top

// [verilog/adcrt_pkg.sv]
// constants, types and register map of the read-triggered converter control block
// What this block does
// - a processor read of the conversion result register made while the engine is idle starts a new conversion.
// - every read of the result register returns the latest sample together with engine status.
// - bit 31 is the completion flag, and a zero there tells software to read again.
// - the sample sits in the low 16 bits and software masks off everything above them.
// - a read made while a conversion runs leaves that conversion untouched.
// - divider register bit 16 picks reference divided by 4 when clear, by 16 when set.
package adcrt_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADCRT_RESULT_OFS = 8'h00;
  localparam logic [7:0] ADCRT_CLKDIV_OFS = 8'h04;
  localparam logic [7:0] ADCRT_INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] ADCRT_INT_MASK_OFS = 8'h0c;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int ADCRT_DIV_SEL_BIT = 16;
  localparam int ADCRT_INT_DONE_BIT = 0;
  localparam logic ADCRT_DIV_SEL_RST = 1'h0;
  localparam logic ADCRT_INT_STATUS_RST = 1'h0;
  localparam logic ADCRT_INT_MASK_RST = 1'h0;
  localparam logic [15:0] ADCRT_SAMPLE_RST = 16'h0000;

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam logic [3:0] ADCRT_DIV_FAST = 4'h3;
  localparam logic [3:0] ADCRT_DIV_SLOW = 4'hf;
  localparam logic [4:0] ADCRT_CONV_TICKS = 5'h10;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [0:0] {
    ADCRT_IDLE = 1'b0,
    ADCRT_CONV = 1'b1
  } adcrt_state_t;

  typedef struct packed {
    logic done;
    logic [14:0] rsvd;
    logic [15:0] sample;
  } adcrt_result_t;

endpackage

// [verilog/adcrt_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module adcrt_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic async_in,
  output logic level
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // first stage feeds only the second
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule // adcrt_sync

// [verilog/adcrt_clkdiv.sv]
// converter clock divider: reference edges divided by 4 or 16
`timescale 1ns/1ps
module adcrt_clkdiv
  import adcrt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ref_rise,
  input wire logic div_sel,
  output logic conv_tick
);
  logic [3:0] cnt_q, cnt_d, limit;
  logic tick_q, tick_d;

  always_comb begin
    limit = div_sel ? ADCRT_DIV_SLOW : ADCRT_DIV_FAST;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (ref_rise) begin
      if (cnt_q >= limit) begin
        cnt_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign conv_tick = tick_q;
endmodule // adcrt_clkdiv

// [dv/adcrt_assertions.sv]
// concurrent checks on the converter block's result reads and engine status
`timescale 1ns/1ps
module adcrt_chk
  import adcrt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic conversion_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // done tracking
  // ----------------------------------------
  logic fin_q, fin_d, busy_q, exp_q;
  wire rd_res = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ADCRT_RESULT_OFS;
  wire rd_any = hsel && htrans[1] && hready && !hwrite;
  // end of a conversion wins over a same-cycle trigger
  always_comb begin
    fin_d = fin_q;
    if (busy_q && !conversion_busy) fin_d = 1'h1;
    else if (rd_res && !conversion_busy) fin_d = 1'h0;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fin_q <= 1'h0;
      busy_q <= 1'h0;
      exp_q <= 1'h0;
    end else begin
      fin_q <= fin_d;
      busy_q <= conversion_busy;
      exp_q <= fin_q | busy_q;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_trig; rd_res && !conversion_busy; endsequence
  sequence s_poll; rd_res && conversion_busy; endsequence
  property p_start; s_trig |=> conversion_busy; endproperty
  property p_cause; $rose(conversion_busy) |-> $past(rd_res); endproperty
  property p_poll; s_poll |=> !hrdata[31]; endproperty
  property p_hi; rd_res |=> hrdata[30:16] == 15'h0; endproperty
  property p_done; s_trig |=> hrdata[31] == exp_q; endproperty
  // read data must stand until the next read is taken
  property p_hold; !rd_any |=> $stable(hrdata); endproperty
  a_start: assert property (p_start)
    else $error("idle result read did not start a conversion");
  a_cause: assert property (p_cause)
    else $error("conversion started without a result read");
  a_poll: assert property (p_poll)
    else $error("done flag set while converting");
  a_hi: assert property (p_hi)
    else $error("result bits 30 to 16 not zero");
  a_done: assert property (p_done)
    else $error("done flag wrong on idle read");
  a_hold: assert property (p_hold)
    else $error("read data changed without a read");
endmodule // adcrt_chk

// [dv/tb_top.sv]
// self-checking bench for the read-triggered converter block
`timescale 1ns/1ps
module tb_top;
  import adcrt_pkg::*;
  logic clock = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, done_x = 1'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'h7e0940c7;
  logic [1:0] htrans = 2'h0;
  logic [15:0] analog_code = '0, prev = '0;
  logic [2:0] refc = 3'h0;
  logic hreadyout, hresp, conversion_busy, irq;
  int fail_count = 0, n_tests = 0;
  adcrt_top dut_u (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_ref_clk(refc[2]), .analog_code(analog_code),
    .conversion_busy(conversion_busy), .irq(irq));
  initial forever #50 clock = ~clock;
  // reference at an eighth of the clock, slow enough for the synchroniser
  always @(posedge clock) refc <= refc + 3'h1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [31:0] res(input logic d, input logic [15:0] s);
    return {d, 15'h0, s};
  endfunction
  function automatic logic [31:0] sx(input logic [15:0] s);
    return {{16{s[15]}}, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic end_sim();
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one conversion: trigger, two polls, wait, then the interrupt path
  task automatic run(input logic m, input logic d);
    int n;
    int e;
    bus(1'h1, ADCRT_CLKDIV_OFS, {15'h0, d, 16'h0});
    bus(1'h1, ADCRT_INT_MASK_OFS, {31'h0, m});
    seed = xs(seed);
    analog_code <= seed[15:0];
    bus(1'h0, ADCRT_RESULT_OFS, '0);
    chk(rd, res(done_x, prev));
    for (n = 0; n < 2; n++) begin
      bus(1'h0, ADCRT_RESULT_OFS, '0);
      chk(rd, res(1'h0, prev));
    end
    n = 0;
    while (conversion_busy !== 1'h0 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    // free-running divider phase costs up to one divided tick
    e = ADCRT_CONV_TICKS * (d ? 128 : 32);
    chk(n > e - (d ? 136 : 40) && n < e + 16, 1'h1);
    prev = seed[15:0];
    done_x = 1'h1;
    chk(irq, m);
    bus(1'h0, ADCRT_INT_STATUS_OFS, '0);
    chk(rd, 32'h1);
    bus(1'h1, ADCRT_INT_STATUS_OFS, 32'h1);
    // clear lands at the edge ending the data phase; the pause also spaces triggers
    repeat (4) @(posedge clock);
    chk(irq, 1'h0);
    $display("run done mask=%0d div=%0d cycles=%0d", m, d, n);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    for (int i = 1; i < 5; i++) begin
      bus(1'h0, 8'(4 * i), '0);
      chk(rd, '0);
      chk(hresp, 1'h0);
    end
    $display("reset values done");
    run(1'h1, 1'h0);
    run(1'h0, 1'h1);
    repeat (2) begin
      seed = xs(seed);
      run(seed[3], seed[7]);
    end
    bus(1'h0, ADCRT_RESULT_OFS, '0);
    chk(rd, res(1'h1, prev));
    chk(sx(rd[15:0]), sx(prev));
    end_sim();
  end
  initial begin
    #3000000;
    fail_count++;
    end_sim();
  end
endmodule // tb_top
bind adcrt_top adcrt_chk chk_u (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .conversion_busy(conversion_busy));
